/* File: sim/ptfsc_mac_model.sv */
`timescale 1ns/1ps
module ptfsc_mac_model #(
    parameter [2:0] MAC_MIN_PRE = 3'h2
) (
    // clock
    input  wire       clk_in,
    // status frame settings seen by the mac
    input  wire       sf_active_in,
    input  wire [2:0] min_preamble_in,
    // acceptance
    output reg        frame_ok_out
);
    // a short preamble below the mac's own minimum loses the frame
    always @(posedge clk_in) begin
        frame_ok_out <= sf_active_in &&
            (min_preamble_in >= MAC_MIN_PRE);
    end
endmodule

/* File: sim/ptfsc_properties.sv */
`timescale 1ns/1ps
`include "ptfsc_regs.vh"
module ptfsc_properties (
    // clock and reset
    input wire        CLK_SYS_IN,
    input wire        RST_IN,
    // apb
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [31:0] PRDATA_OUT,
    input wire        PREADY_OUT,
    input wire        PSLVERR_OUT,
    // interrupt and configuration views
    input wire        IRQ_OUT,
    input wire        TX_CAPTURE_EN_OUT,
    input wire        SF_ACTIVE_OUT,
    input wire [2:0]  SF_MIN_PREAMBLE_OUT,
    input wire        SF_IP_TYPE_OUT,
    input wire [15:0] UDP_EVENT_PORT_OUT
);
    // completed write; views are registered, so checked two edges later
    wire [9:0] idx = PADDR_IN[11:2];
    wire       wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    wire       wa = wr && idx == `PTFSC_IDX_TXCFG_A;
    wire       ws = wr && idx == `PTFSC_IDX_SF_CFG;
    wire       mapped = (idx >= 10'h16 && idx <= 10'h18) ||
                        (idx >= 10'h20 && idx <= 10'h28);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    ready_one_wait_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT
        && !$past(PENABLE_IN) |=> PREADY_OUT) else $error("pready late");
    ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("pready held");
    capture_copy_a: assert property (wa |-> ##2
        TX_CAPTURE_EN_OUT == $past(PWDATA_IN[0], 2)) else $error("capture");
    udp_port_sel_a: assert property (wa |-> ##2
        UDP_EVENT_PORT_OUT ==
        ($past(PWDATA_IN[12], 2) ? 16'h007B : 16'h013F)) else $error("port");
    preamble_copy_a: assert property (ws |-> ##2
        SF_MIN_PREAMBLE_OUT == $past(PWDATA_IN[10:8], 2)) else $error("pre");
    ip_type_a: assert property (ws |-> ##2
        SF_IP_TYPE_OUT == $past(PWDATA_IN[6], 2)) else $error("ip type");
    sf_active_a: assert property (ws |-> ##2
        SF_ACTIVE_OUT ==
        ($past(PWDATA_IN[5:0] & 6'h2F, 2) != 6'h0)) else $error("active");
    sf_reserved_a: assert property (PREADY_OUT && !PWRITE_IN &&
        idx == `PTFSC_IDX_SF_CFG |-> PRDATA_OUT[31:13] == 19'h0)
        else $error("reserved bits");
    unmapped_err_a: assert property (PREADY_OUT && !mapped |->
        PSLVERR_OUT && PRDATA_OUT == 32'h0) else $error("unmapped");
    cover property (ws);
    cover property (PSLVERR_OUT);
    cover property (IRQ_OUT);
endmodule
bind ptfsc_top ptfsc_properties u_ptfsc_properties (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .IRQ_OUT(IRQ_OUT),
    .TX_CAPTURE_EN_OUT(TX_CAPTURE_EN_OUT), .SF_ACTIVE_OUT(SF_ACTIVE_OUT),
    .SF_MIN_PREAMBLE_OUT(SF_MIN_PREAMBLE_OUT),
    .SF_IP_TYPE_OUT(SF_IP_TYPE_OUT), .UDP_EVENT_PORT_OUT(UDP_EVENT_PORT_OUT));

/* File: sim/ptp_tx_filter_status_frame_cfg_tb_top.sv */
`timescale 1ns/1ps
`include "ptfsc_regs.vh"
module ptp_tx_filter_status_frame_cfg_tb_top;
    // arbitrary addresses, chosen for this bench only
    localparam [47:0] FA0 = 48'h02_00_00_00_00_11;
    localparam [47:0] FA1 = 48'h02_00_00_00_00_22;
    localparam [47:0] MCA = 48'h01_00_5E_00_00_33;
    reg          clk = 1'b0;
    reg          rst = 1'b1;
    reg          psel = 1'b0;
    reg          pen = 1'b0;
    reg          pwr = 1'b0;
    reg   [11:0] paddr = 12'h000;
    reg   [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, cap, act, ipt, mac_ok;
    wire  [2:0]  pre;
    wire  [15:0] port;
    int          miscompares = 0;
    int          checks = 0;
    int          k;
    logic [31:0] s = 32'h08BD, rd, cfg, flt, sf, mv;
    logic [47:0] ad;
    logic [2:0]  kd;
    logic [1:0]  enc;
    logic        er, sent, fx, ax;
    logic [3:0]  iq;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    ptfsc_top #(.FACTORY_ADDR_0(FA0), .FACTORY_ADDR_1(FA1),
        .MCAST_DEST(MCA)) u_ptfsc_top (
        .CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .IRQ_OUT(irq), .TX_CAPTURE_EN_OUT(cap), .SF_ACTIVE_OUT(act),
        .SF_MIN_PREAMBLE_OUT(pre), .SF_IP_TYPE_OUT(ipt),
        .UDP_EVENT_PORT_OUT(port));
    ptfsc_mac_model u_ptfsc_mac_model (.clk_in(clk), .sf_active_in(act),
        .min_preamble_in(pre), .frame_ok_out(mac_ok));
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // 32 shifts per draw so successive values are not just shifted copies
    function logic [31:0] lfsr(input logic [31:0] v);
        for (int i = 0; i < 32; i++)
            v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction
    // one apb transfer; no slave latency assumed, only a hang limit
    task apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        // answer signals are read as they stood at each rising edge
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40)
            miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // reference decision of the transmit filter
    function logic fexp(input logic [31:0] c, f, m, input logic [1:0] e,
                        input logic u);
        logic ok;
        ok = c[0] && (e == 2'h0 ? c[7] : e == 2'h1 ? c[6] : c[5]);
        ok = ok && (c[4:1] == 4'h0 || c[4:1] == m[3:0]);
        ok = ok && (((m[15:8] ^ f[7:0]) & f[15:8]) == 8'h0);
        if (e != 2'h0 && u)
            ok = ok && (m[31:16] == (c[12] ? 16'h007B : 16'h013F));
        return ok;
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 3; k++) begin
            apb(1'b0, 8'(`PTFSC_IDX_TXCFG_A + k), 0);
            cmp("cfg reset", 0, rd);
        end
        cmp("cap reset", 0, cap);
        cmp("port reset", 32'h13F, port);
        $display("test reset done");
        apb(1'b1, `PTFSC_IDX_SF_CFG, 32'hFFFF_FFFF);
        apb(1'b0, `PTFSC_IDX_SF_CFG, 0);
        cmp("sf cfg", 32'h1FFF, rd);
        apb(1'b1, 8'h3F, 32'h1234);
        cmp("unmapped wr", 1, er);
        apb(1'b0, 8'h3F, 0);
        cmp("unmapped rd", 0, rd);
        cmp("unmapped err", 1, er);
        $display("test access done");
        // random filter settings, messages biased toward near matches
        for (k = 0; k < 48; k++) begin
            s = lfsr(s);
            cfg = s & 32'h10FF;
            s = lfsr(s);
            flt = s[16] ? s & 32'h00FF : s & 32'hFFFF;
            s = lfsr(s);
            mv[31:16] = s[17] ? 16'h013F : (s[18] ? 16'h007B : s[31:16]);
            mv[15:0] = {s[4] ? flt[7:0] : s[15:8], 4'h0,
                        s[0] ? cfg[4:1] : s[3:0]};
            enc = (s[6:5] == 2'h3) ? 2'h2 : s[6:5];
            apb(1'b1, `PTFSC_IDX_TXCFG_A, cfg);
            apb(1'b1, `PTFSC_IDX_TX_FILTER, flt);
            apb(1'b1, `PTFSC_IDX_MSG_VALUE, mv);
            apb(1'b1, `PTFSC_IDX_MSG_CTRL, {29'h0, s[7], enc});
            apb(1'b0, `PTFSC_IDX_RESULT, 0);
            fx = fexp(cfg, flt, mv, enc, s[7]);
            cmp("filter", {31'h1, fx}, rd);
            cmp("capture en", cfg[0], cap);
            cmp("udp port", cfg[12] ? 32'h7B : 32'h13F, port);
        end
        $display("test filter done");
        apb(1'b1, `PTFSC_IDX_IRQ_STATUS, 32'hF);
        apb(1'b1, `PTFSC_IDX_IRQ_MASK, 32'h1);
        apb(1'b1, `PTFSC_IDX_TXCFG_A, 32'h81);
        apb(1'b1, `PTFSC_IDX_TX_FILTER, 0);
        apb(1'b1, `PTFSC_IDX_MSG_CTRL, 0);
        apb(1'b0, `PTFSC_IDX_IRQ_STATUS, 0);
        cmp("status accept", 1, rd);
        cmp("irq raised", 1, irq);
        apb(1'b1, `PTFSC_IDX_IRQ_STATUS, 32'h1);
        apb(1'b0, `PTFSC_IDX_IRQ_STATUS, 0);
        cmp("status clear", 0, rd);
        cmp("irq clear", 0, irq);
        apb(1'b1, `PTFSC_IDX_TXCFG_A, 0);
        apb(1'b1, `PTFSC_IDX_MSG_CTRL, 0);
        apb(1'b0, `PTFSC_IDX_IRQ_STATUS, 0);
        cmp("status reject", 2, rd);
        cmp("irq masked", 0, irq);
        $display("test irq done");
        iq = 4'h2;
        // every frame kind under random delivery enables
        for (k = 0; k < 30; k++) begin
            s = lfsr(s);
            sf = s & 32'h1FFF;
            kd = 3'(k % 6);
            apb(1'b1, `PTFSC_IDX_SF_CFG, sf);
            apb(1'b1, `PTFSC_IDX_SF_VALUE, {13'h0, kd, s[31:16]});
            apb(1'b0, `PTFSC_IDX_SF_RESULT, 0);
            sent = kd == 3'h5 ? sf[5] : kd == 3'h4 ?
                   sf[4] && (sf[5] || sf[3:0] != 0) : sf[3 - kd];
            iq = iq | (sent ? 4'h4 : 4'h8);
            ax = sf[5] || sf[3:0] != 0;
            mv[15:0] = sf[7] ? {s[23:16], s[31:24]} : s[31:16];
            cmp("sf sent", sent, rd[16]);
            if (sent)
                cmp("sf word", mv[15:0], rd[15:0]);
            cmp("sf active", ax, act);
            cmp("preamble", sf[10:8], pre);
            cmp("ip type", sf[6], ipt);
            cmp("mac ok", ax && sf[10:8] >= 2, mac_ok);
            ad = sf[12:11] == 0 ? FA0 : sf[12:11] == 1 ? FA1 :
                 sf[12:11] == 2 ? MCA : 48'h0;
            apb(1'b0, `PTFSC_IDX_SRC_ADDR_LO, 0);
            cmp("src lo", ad[31:0], rd);
            apb(1'b0, `PTFSC_IDX_SRC_ADDR_HI, 0);
            cmp("src hi", ad[47:32], rd);
        end
        apb(1'b0, `PTFSC_IDX_IRQ_STATUS, 0);
        cmp("status sf", {28'h0, iq}, rd);
        $display("test status frame done");
        // a reset in mid-run must clear every configuration register
        for (k = 0; k < 3; k++)
            apb(1'b1, 8'(`PTFSC_IDX_TXCFG_A + k), 32'hFFFF);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 3; k++) begin
            apb(1'b0, 8'(`PTFSC_IDX_TXCFG_A + k), 0);
            cmp("cfg rearm", 0, rd);
        end
        cmp("cap rearm", 0, cap);
        cmp("act rearm", 0, act);
        cmp("port rearm", 32'h13F, port);
        cmp("irq rearm", 0, irq);
        $display("test mid reset done");
        results;
    end
    // hang guard, well beyond the fewer than two thousand cycles the tests use
    initial begin
        #(25 * 10000);
        miscompares++;
        results;
    end
    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
endmodule

/* File: verilog/ptfsc_regs.vh */
`ifndef PTFSC_REGS_VH
`define PTFSC_REGS_VH

// register indices; byte address is four times the index
`define PTFSC_IDX_TXCFG_A       8'h16
`define PTFSC_IDX_TX_FILTER     8'h17
`define PTFSC_IDX_SF_CFG        8'h18
`define PTFSC_IDX_IRQ_STATUS    8'h20
`define PTFSC_IDX_IRQ_MASK      8'h21
`define PTFSC_IDX_MSG_VALUE     8'h22
`define PTFSC_IDX_MSG_CTRL      8'h23
`define PTFSC_IDX_RESULT        8'h24
`define PTFSC_IDX_SF_VALUE      8'h25
`define PTFSC_IDX_SF_RESULT     8'h26
`define PTFSC_IDX_SRC_ADDR_LO   8'h27
`define PTFSC_IDX_SRC_ADDR_HI   8'h28

// first transmit configuration fields
`define PTFSC_TX_L2_BIT         7
`define PTFSC_TX_IPV6_BIT       6
`define PTFSC_TX_IPV4_BIT       5
`define PTFSC_TX_VER_HI         4
`define PTFSC_TX_VER_LO         1
`define PTFSC_TX_CAP_BIT        0
`define PTFSC_ALT_PROTO_BIT     12

// status frame configuration fields
`define PTFSC_SF_WMASK          13'h1FFF
`define PTFSC_SF_SRC_HI         12
`define PTFSC_SF_SRC_LO         11
`define PTFSC_SF_PRE_HI         10
`define PTFSC_SF_PRE_LO         8
`define PTFSC_SF_SWAP_BIT       7
`define PTFSC_SF_IP_BIT         6
`define PTFSC_SF_CTRL_BIT       5
`define PTFSC_SF_ERR_BIT        4
`define PTFSC_SF_TX_BIT         3
`define PTFSC_SF_RX_BIT         2
`define PTFSC_SF_TRIG_BIT       1
`define PTFSC_SF_EVT_BIT        0

// encapsulation codes and udp ports
`define PTFSC_ENC_L2            2'h0
`define PTFSC_ENC_IPV6          2'h1
`define PTFSC_ENC_IPV4          2'h2
`define PTFSC_PORT_EVENT        16'h013F
`define PTFSC_PORT_ALT          16'h007B

// source address codes
`define PTFSC_SRC_FACT0         2'h0
`define PTFSC_SRC_FACT1         2'h1
`define PTFSC_SRC_MCAST         2'h2
`define PTFSC_SRC_ZERO          2'h3

// status frame kind codes
`define PTFSC_KIND_TX           3'h0
`define PTFSC_KIND_RX           3'h1
`define PTFSC_KIND_TRIG         3'h2
`define PTFSC_KIND_EVT          3'h3
`define PTFSC_KIND_ERR          3'h4
`define PTFSC_KIND_CTRL         3'h5

// interrupt status bits
`define PTFSC_IRQ_STAMP_BIT     0
`define PTFSC_IRQ_SKIP_BIT      1
`define PTFSC_IRQ_SF_BIT        2
`define PTFSC_IRQ_SF_DROP_BIT   3

`endif

/* File: verilog/ptfsc_top.v */
// Behaviour
// - layer-2 transmit messages are recognised only while bit 7 is set
// - UDP/IPv6 transmit messages are recognised only while bit 6 is set
// - UDP/IPv4 transmit messages are recognised only while bit 5 is set
// - nonzero version field 4:1 must equal the message version
// - version field zero skips the version comparison
// - no transmit capture unless capture enable bit 0 is set
// - all-zero mask bypasses the first byte filter
// - source select: two factory addresses, multicast, or all zero
// - bits 10:8 give minimum preamble bytes before status frames
// - 16-bit fields go high byte first, swapped when bit 7 set
// - bit 6 picks layer-2 (zero) or IPv4 (one) status frames
// - bit 4 reports errors but alone starts no status frames
// - bits 3..0 enable tx, rx, trigger and event delivery
// - status config bits 31..13 ignore writes and read zero
// - UDP event port is 319, or 123 with the alternate select
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "ptfsc_regs.vh"

module ptfsc_top (
    // clock and reset
    input  wire        CLK_SYS_IN,
    input  wire        RST_IN,
    // apb slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    // interrupt
    output reg         IRQ_OUT,
    // configuration views for the datapath
    output reg         TX_CAPTURE_EN_OUT,
    output reg         SF_ACTIVE_OUT,
    output reg  [2:0]  SF_MIN_PREAMBLE_OUT,
    output reg         SF_IP_TYPE_OUT,
    output reg  [15:0] UDP_EVENT_PORT_OUT
);

    // arbitrary neutral factory addresses, not any real maker's
    parameter [47:0] FACTORY_ADDR_0 = 48'h02_00_00_00_00_01;
    parameter [47:0] FACTORY_ADDR_1 = 48'h02_00_00_00_00_02;
    parameter [47:0] MCAST_DEST     = 48'h01_00_5E_00_00_01;

    // configuration registers
    reg [15:0] tx_cfg_a;
    reg [15:0] tx_filter;
    reg [12:0] sf_cfg;
    reg [3:0]  irq_status;
    reg [3:0]  irq_mask;
    // message under test, written by software to exercise the filter
    reg [7:0]  msg_first_byte;
    reg [3:0]  msg_version;
    reg [1:0]  msg_encap;
    reg [15:0] msg_port;
    reg        msg_is_udp;
    reg        msg_go;
    reg        res_accept;
    reg        res_valid;
    // status frame request
    reg [15:0] sf_value;
    reg [2:0]  sf_kind;
    reg        sf_go;
    reg [15:0] sf_out_word;
    reg        sf_sent;
    reg [47:0] sf_src_addr;

    // apb decode; every register is one aligned word, so the two low
    // address bits are ignored rather than checked
    wire [9:0] word_idx = PADDR_IN[11:2];
    wire       apb_access = PSEL_IN & PENABLE_IN;
    wire       apb_wr = apb_access & PWRITE_IN;

    // named views of the transmit configuration fields
    wire       tx_layer2_detect_en = tx_cfg_a[`PTFSC_TX_L2_BIT];
    wire       tx_ipv6_detect_en = tx_cfg_a[`PTFSC_TX_IPV6_BIT];
    wire       tx_ipv4_detect_en = tx_cfg_a[`PTFSC_TX_IPV4_BIT];
    wire [3:0] tx_version_match  =
        tx_cfg_a[`PTFSC_TX_VER_HI:`PTFSC_TX_VER_LO];
    wire       tx_capture_en     = tx_cfg_a[`PTFSC_TX_CAP_BIT];
    wire       alt_time_protocol_sel = tx_cfg_a[`PTFSC_ALT_PROTO_BIT];
    wire [7:0] first_byte_mask   = tx_filter[15:8];
    wire [7:0] first_byte_value  = tx_filter[7:0];

    // named views of the status frame configuration fields
    wire [1:0] status_frame_src_sel      =
        sf_cfg[`PTFSC_SF_SRC_HI:`PTFSC_SF_SRC_LO];
    wire [2:0] sf_min_preamble           =
        sf_cfg[`PTFSC_SF_PRE_HI:`PTFSC_SF_PRE_LO];
    wire       status_frame_byte_swap    = sf_cfg[`PTFSC_SF_SWAP_BIT];
    wire       status_frame_ip_type      = sf_cfg[`PTFSC_SF_IP_BIT];
    wire       status_frame_ctrl_read_en = sf_cfg[`PTFSC_SF_CTRL_BIT];
    wire       status_frame_error_en     = sf_cfg[`PTFSC_SF_ERR_BIT];
    wire       status_frame_tx_stamp_en  = sf_cfg[`PTFSC_SF_TX_BIT];
    wire       status_frame_rx_stamp_en  = sf_cfg[`PTFSC_SF_RX_BIT];
    wire       status_frame_trigger_en   = sf_cfg[`PTFSC_SF_TRIG_BIT];
    wire       status_frame_event_en     = sf_cfg[`PTFSC_SF_EVT_BIT];

    // match a word index against a register index
    function hit;
        input [9:0] idx;
        input [7:0] reg_idx;
        begin
            hit = (idx == {2'h0, reg_idx});
        end
    endfunction

    // swap the two bytes of a 16-bit field when asked
    function [15:0] order16;
        input [15:0] val;
        input        swap;
        begin
            order16 = swap ? {val[7:0], val[15:8]} : val;
        end
    endfunction

    // encapsulation gate; code 3 names no encapsulation and so is
    // never recognised, whatever the detect enables say
    reg encap_ok;
    always @* begin
        case (msg_encap)
            `PTFSC_ENC_L2:   encap_ok = tx_layer2_detect_en;
            `PTFSC_ENC_IPV6: encap_ok = tx_ipv6_detect_en;
            `PTFSC_ENC_IPV4: encap_ok = tx_ipv4_detect_en;
            default:         encap_ok = 1'b0;
        endcase
    end

    // udp messages must use the selected event port
    wire [15:0] event_port = alt_time_protocol_sel ?
        `PTFSC_PORT_ALT : `PTFSC_PORT_EVENT;
    wire port_ok = (msg_encap == `PTFSC_ENC_L2) || !msg_is_udp ||
        (msg_port == event_port);

    // version check is skipped entirely when the field is zero
    wire version_ok = (tx_version_match == 4'h0) ||
        (tx_version_match == msg_version);

    // masked compare; an all-zero mask compares nothing and so passes
    wire byte_ok = ((msg_first_byte ^ first_byte_value) &
        first_byte_mask) == 8'h00;
    wire filter_bypass = (first_byte_mask == 8'h00);

    wire next_accept = tx_capture_en & encap_ok & port_ok &
        version_ok & (filter_bypass | byte_ok);

    // generation runs while any main delivery enable is set; the error
    // enable only rides along, so bit 4 alone starts no status frames
    wire sf_any_main = status_frame_ctrl_read_en |
        status_frame_tx_stamp_en | status_frame_rx_stamp_en |
        status_frame_trigger_en | status_frame_event_en;

    // per-kind delivery enable
    reg kind_en;
    always @* begin
        case (sf_kind)
            `PTFSC_KIND_TX:   kind_en = status_frame_tx_stamp_en;
            `PTFSC_KIND_RX:   kind_en = status_frame_rx_stamp_en;
            `PTFSC_KIND_TRIG: kind_en = status_frame_trigger_en;
            `PTFSC_KIND_EVT:  kind_en = status_frame_event_en;
            `PTFSC_KIND_ERR:  kind_en = status_frame_error_en &
                                        sf_any_main;
            `PTFSC_KIND_CTRL: kind_en = status_frame_ctrl_read_en;
            default:          kind_en = 1'b0;
        endcase
    end

    // source address selection
    reg [47:0] next_src_addr;
    always @* begin
        case (status_frame_src_sel)
            `PTFSC_SRC_FACT0: next_src_addr = FACTORY_ADDR_0;
            `PTFSC_SRC_FACT1: next_src_addr = FACTORY_ADDR_1;
            `PTFSC_SRC_MCAST: next_src_addr = MCAST_DEST;
            default:          next_src_addr = 48'h0;
        endcase
    end

    // read mux; unmapped words read zero and flag an error
    // an error answer still takes the same single wait state
    reg [31:0] rd_mux;
    reg        rd_hit;
    always @* begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (hit(word_idx, `PTFSC_IDX_TXCFG_A)) begin
            rd_mux = {16'h0, tx_cfg_a};
        end else if (hit(word_idx, `PTFSC_IDX_TX_FILTER)) begin
            rd_mux = {16'h0, tx_filter};
        end else if (hit(word_idx, `PTFSC_IDX_SF_CFG)) begin
            rd_mux = {19'h0, sf_cfg};
        end else if (hit(word_idx, `PTFSC_IDX_IRQ_STATUS)) begin
            rd_mux = {28'h0, irq_status};
        end else if (hit(word_idx, `PTFSC_IDX_IRQ_MASK)) begin
            rd_mux = {28'h0, irq_mask};
        end else if (hit(word_idx, `PTFSC_IDX_MSG_VALUE)) begin
            rd_mux = {msg_port, msg_first_byte, 4'h0, msg_version};
        end else if (hit(word_idx, `PTFSC_IDX_MSG_CTRL)) begin
            rd_mux = {29'h0, msg_is_udp, msg_encap};
        end else if (hit(word_idx, `PTFSC_IDX_RESULT)) begin
            rd_mux = {30'h0, res_valid, res_accept};
        end else if (hit(word_idx, `PTFSC_IDX_SF_VALUE)) begin
            rd_mux = {13'h0, sf_kind, sf_value};
        end else if (hit(word_idx, `PTFSC_IDX_SF_RESULT)) begin
            rd_mux = {15'h0, sf_sent, sf_out_word};
        end else if (hit(word_idx, `PTFSC_IDX_SRC_ADDR_LO)) begin
            rd_mux = sf_src_addr[31:0];
        end else if (hit(word_idx, `PTFSC_IDX_SRC_ADDR_HI)) begin
            rd_mux = {16'h0, sf_src_addr[47:32]};
        end else begin
            rd_mux = 32'h0;
            rd_hit = 1'b0;
        end
    end

    // events raised this cycle
    // accept and skip are exclusive, so each launch sets one bit
    wire ev_stamp = msg_go & next_accept;
    wire ev_skip  = msg_go & ~next_accept;
    wire ev_sf    = sf_go & kind_en;
    wire ev_drop  = sf_go & ~kind_en;
    wire [3:0] ev_vec = {ev_drop, ev_sf, ev_skip, ev_stamp};
    wire st_clr_wr = apb_wr & PREADY_OUT &
        hit(word_idx, `PTFSC_IDX_IRQ_STATUS);

    // apb slave: one wait state, so every access answers on its second
    // access-phase edge; writes take effect on that edge only
    // registering the answer costs a cycle but keeps every output a flop
    always @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            tx_cfg_a       <= 16'h0;
            tx_filter      <= 16'h0;
            sf_cfg         <= 13'h0;
            irq_mask       <= 4'h0;
            msg_first_byte <= 8'h0;
            msg_version    <= 4'h0;
            msg_encap      <= 2'h0;
            msg_port       <= 16'h0;
            msg_is_udp     <= 1'b0;
            msg_go         <= 1'b0;
            sf_value       <= 16'h0;
            sf_kind        <= 3'h0;
            sf_go          <= 1'b0;
            PREADY_OUT     <= 1'b0;
            PRDATA_OUT     <= 32'h0;
            PSLVERR_OUT    <= 1'b0;
        end else begin
            msg_go <= 1'b0;
            sf_go  <= 1'b0;
            PREADY_OUT  <= apb_access & ~PREADY_OUT;
            PSLVERR_OUT <= apb_access & ~PREADY_OUT & ~rd_hit;
            PRDATA_OUT  <= (apb_access & ~PREADY_OUT & ~PWRITE_IN) ?
                rd_mux : 32'h0;
            if (apb_wr & PREADY_OUT) begin
                if (hit(word_idx, `PTFSC_IDX_TXCFG_A))
                    tx_cfg_a <= PWDATA_IN[15:0];
                if (hit(word_idx, `PTFSC_IDX_TX_FILTER))
                    tx_filter <= PWDATA_IN[15:0];
                if (hit(word_idx, `PTFSC_IDX_SF_CFG))
                    sf_cfg <= PWDATA_IN[12:0] &
                        `PTFSC_SF_WMASK;
                if (hit(word_idx, `PTFSC_IDX_IRQ_MASK))
                    irq_mask <= PWDATA_IN[3:0];
                if (hit(word_idx, `PTFSC_IDX_MSG_VALUE)) begin
                    msg_port       <= PWDATA_IN[31:16];
                    msg_first_byte <= PWDATA_IN[15:8];
                    msg_version    <= PWDATA_IN[3:0];
                end
                // writing the control word launches the check
                if (hit(word_idx, `PTFSC_IDX_MSG_CTRL)) begin
                    msg_encap  <= PWDATA_IN[1:0];
                    msg_is_udp <= PWDATA_IN[2];
                    msg_go     <= 1'b1;
                end
                if (hit(word_idx, `PTFSC_IDX_SF_VALUE)) begin
                    sf_value <= PWDATA_IN[15:0];
                    sf_kind  <= PWDATA_IN[18:16];
                    sf_go    <= 1'b1;
                end
            end
        end
    end

    // filter verdict and status frame word, one cycle after launch
    // results hold until the next launch so software may poll them
    always @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            res_accept  <= 1'b0;
            res_valid   <= 1'b0;
            sf_out_word <= 16'h0;
            sf_sent     <= 1'b0;
            sf_src_addr <= 48'h0;
        end else begin
            sf_src_addr <= next_src_addr;
            if (msg_go) begin
                res_accept <= next_accept;
                res_valid  <= 1'b1;
            end
            if (sf_go) begin
                sf_sent     <= kind_en;
                sf_out_word <= kind_en ? order16(sf_value,
                    status_frame_byte_swap) : 16'h0;
            end
        end
    end

    // sticky status; a new event beats a same-cycle write-one clear
    // irq trails status by one cycle because it too is registered
    always @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            irq_status <= 4'h0;
            IRQ_OUT    <= 1'b0;
        end else begin
            irq_status <= (irq_status &
                ~(st_clr_wr ? PWDATA_IN[3:0] : 4'h0)) | ev_vec;
            IRQ_OUT    <= |(irq_status & irq_mask);
        end
    end

    // configuration views, registered so each output is a flop
    // the udp port resets to the event port, as a clear select implies
    always @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            TX_CAPTURE_EN_OUT   <= 1'b0;
            SF_ACTIVE_OUT       <= 1'b0;
            SF_MIN_PREAMBLE_OUT <= 3'h0;
            SF_IP_TYPE_OUT      <= 1'b0;
            UDP_EVENT_PORT_OUT  <= `PTFSC_PORT_EVENT;
        end else begin
            TX_CAPTURE_EN_OUT   <= tx_capture_en;
            SF_ACTIVE_OUT       <= sf_any_main;
            SF_MIN_PREAMBLE_OUT <= sf_min_preamble;
            SF_IP_TYPE_OUT      <= status_frame_ip_type;
            UDP_EVENT_PORT_OUT  <= event_port;
        end
    end

endmodule
